// file: src/casm_alarm.sv
`timescale 1ns/1ps
`default_nettype none
`include "casm_defs.svh"
// Alarm status and mask block: hysteretic per-channel comparators,
// status registers per alarm output, masks and active-low alarm pins.
module casm_alarm (
  input  wire logic                CORE_CLK,
  input  wire logic                RST_B,
  input  wire logic                CLK_EN,
  input  wire logic                UPDATE,
  input  wire casm_pkg::casm_temps_t READING,
  input  wire casm_pkg::casm_temps_t FIRST_LIMIT,
  input  wire casm_pkg::casm_temps_t SECOND_LIMIT,
  input  wire casm_pkg::casm_chan_t  THIRD_MASK,
  input  wire casm_pkg::casm_cmd_t   CMD,
  output logic [7:0]               RDATA,
  output logic                     ALARM_OUT_FIRST_N,
  output logic                     ALARM_OUT_SECOND_N,
  output logic                     ALARM_OUT_THIRD_N
);
  import casm_pkg::*;

  casm_state_t st_reg;   // Registered state
  casm_state_t st_next;  // Next state

  // ==================================================
  // Hysteretic comparator
  // Set at or above limit, clear below limit minus hysteresis, else hold.
  // The subtraction is nine bits wide so a limit under the hysteresis
  // gives a negative threshold that no reading can fall below.
  function automatic logic hyst_cmp(input logic [7:0] rd, input logic [7:0] lim,
                                    input logic [4:0] hy, input logic prev);
    logic [8:0] low;
    low = {1'b0, lim} - {4'h0, hy};
    if (rd >= lim) begin
      hyst_cmp = 1'b1;
    end else if (!low[8] && ({1'b0, rd} < low)) begin
      hyst_cmp = 1'b0;
    end else begin
      hyst_cmp = prev;
    end
  endfunction

  // Compare all five channels against one limit set
  function automatic casm_chan_t cmp_all(input casm_temps_t rd, input casm_temps_t lim,
                                         input logic [4:0] hy, input casm_chan_t prev);
    casm_chan_t r;
    r[4] = hyst_cmp(rd.remote_four, lim.remote_four, hy, prev[4]);
    r[3] = hyst_cmp(rd.remote_three, lim.remote_three, hy, prev[3]);
    r[2] = hyst_cmp(rd.remote_two, lim.remote_two, hy, prev[2]);
    r[1] = hyst_cmp(rd.remote_one, lim.remote_one, hy, prev[1]);
    r[0] = hyst_cmp(rd.local_c, lim.local_c, hy, prev[0]);
    cmp_all = r;
  endfunction

  // Limit set for second and third outputs: channels four, three and
  // local keep their first limits; remotes two and one use their second limits
  casm_temps_t lim_second;
  always_comb begin
    lim_second              = FIRST_LIMIT;
    lim_second.remote_two   = SECOND_LIMIT.remote_two;
    lim_second.remote_one   = SECOND_LIMIT.remote_one;
  end

  // ==================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Statuses only move on a conversion update
    if (UPDATE) begin
      st_next.first_status  = cmp_all(READING, FIRST_LIMIT, st_reg.hyst,
                                      st_reg.first_status);
      st_next.second_status = cmp_all(READING, lim_second, st_reg.hyst,
                                      st_reg.second_status);
      st_next.third_status  = cmp_all(READING, lim_second, st_reg.hyst,
                                      st_reg.third_status);
    end
    // Register writes; status is read-only so writes to it are dropped
    if (CMD.wr) begin
      case (CMD.cmd)
        `CASM_CMD_FIRST_MASK: begin
          st_next.first_mask = CMD.wdata[4:0];
        end
        `CASM_CMD_SECOND_MASK: begin
          st_next.second_mask = CMD.wdata[4:0];
        end
        `CASM_CMD_HYST: begin
          st_next.hyst = CMD.wdata[4:0];
        end
        default: begin
          st_next.hyst = st_reg.hyst;
        end
      endcase
    end
    // Read mux, registered; upper bits always zero
    case (CMD.cmd)
      `CASM_CMD_THIRD_STATUS: st_next.rdata = {3'h0, st_reg.third_status};
      `CASM_CMD_FIRST_MASK:   st_next.rdata = {3'h0, st_reg.first_mask};
      `CASM_CMD_SECOND_MASK:  st_next.rdata = {3'h0, st_reg.second_mask};
      `CASM_CMD_HYST:         st_next.rdata = {3'h0, st_reg.hyst};
      default:                st_next.rdata = 8'h00;
    endcase
    // Pins low while any unmasked status bit is set; a one in a mask blocks
    st_next.alarm_n[0] = ~|(st_next.first_status & ~st_next.first_mask);
    st_next.alarm_n[1] = ~|(st_next.second_status & ~st_next.second_mask);
    st_next.alarm_n[2] = ~|(st_next.third_status & ~THIRD_MASK);
  end

  // ==================================================
  // State register with synchronous reset and clock enable
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      st_reg               <= '0;
      st_reg.first_mask    <= `CASM_FIRST_MASK_RST;
      st_reg.second_mask   <= `CASM_SECOND_MASK_RST;
      st_reg.hyst          <= `CASM_HYST_RST;
      st_reg.alarm_n       <= 3'h7;
    end else if (CLK_EN) begin
      st_reg <= st_next;
    end
  end

  assign RDATA              = st_reg.rdata;
  assign ALARM_OUT_FIRST_N  = st_reg.alarm_n[0];
  assign ALARM_OUT_SECOND_N = st_reg.alarm_n[1];
  assign ALARM_OUT_THIRD_N  = st_reg.alarm_n[2];
endmodule
`default_nettype wire

// file: src/casm_defs.svh
`ifndef CASM_DEFS_SVH
`define CASM_DEFS_SVH
// Contract
// - Third alarm active while any unmasked status set
// - Status at 0x0A read-only, bits 7-5 zero
// - Bit 4: remote four at/above limit, hysteretic clear
// - Bit 3: remote three at/above limit, hysteretic clear
// - Bit 2: remote two against second limit
// - Bit 1: remote one against second limit
// - Bit 0: local reading against local limit
// - First mask at 0x0C, bits 4-0, reset 0x19
// - First mask bits 4,3 block remote four, three
// - First mask bits 2,1 gate first-limit events
// - First mask bit 0 gates local event
// - Second mask at 0x0D, reset 0x00
// - Second mask bits 3-1 gate remotes three-one
// - Second mask bit 0 gates local event
// - Hysteresis register 0x5A, 0-31, subtracted falling
// - Second limits feed second and third outputs

// ==================================================
// Command bytes
`define CASM_CMD_THIRD_STATUS  8'h0A
`define CASM_CMD_FIRST_MASK    8'h0C
`define CASM_CMD_SECOND_MASK   8'h0D
`define CASM_CMD_HYST          8'h5A
// ==================================================
// Reset values and field widths
`define CASM_FIRST_MASK_RST    5'h19
`define CASM_SECOND_MASK_RST   5'h00
`define CASM_THIRD_MASK_RST    5'h07
`define CASM_HYST_RST          5'h0A
`define CASM_CHANNELS          5
`define CASM_HYST_BITS         5
`define CASM_LIMIT_MAX         9'h0FF
`endif

// file: src/casm_pkg.sv
package casm_pkg;
  // Per-channel vector: bit 4 remote four ... bit 0 local
  typedef logic [4:0] casm_chan_t;
  // Readings and limits arrive as whole degrees, one byte per channel
  typedef struct packed {
    logic [7:0] remote_four;
    logic [7:0] remote_three;
    logic [7:0] remote_two;
    logic [7:0] remote_one;
    logic [7:0] local_c;
  } casm_temps_t;
  // Register access port from the command-byte decoder
  typedef struct packed {
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } casm_cmd_t;
  // Whole block state
  typedef struct packed {
    casm_chan_t first_status;
    casm_chan_t second_status;
    casm_chan_t third_status;
    casm_chan_t first_mask;
    casm_chan_t second_mask;
    logic [4:0] hyst;
    logic [7:0] rdata;
    logic [2:0] alarm_n;
  } casm_state_t;
endpackage

// file: verif/casm_props.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Checker on the alarm block's ports
module casm_props (
  input wire logic                CORE_CLK,
  input wire logic                RST_B,
  input wire logic                CLK_EN,
  input wire logic                UPDATE,
  input wire casm_pkg::casm_cmd_t CMD,
  input wire logic [7:0]          RDATA,
  input wire logic                ALARM_OUT_FIRST_N,
  input wire logic                ALARM_OUT_SECOND_N,
  input wire logic                ALARM_OUT_THIRD_N
);
  import casm_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Reset itself is checked, so no disable here
  reset_idle_a: assert property (disable iff (1'b0) !RST_B |=> RDATA == 8'h00 &&
    ALARM_OUT_FIRST_N && ALARM_OUT_SECOND_N && ALARM_OUT_THIRD_N) else $error("reset state");
  status_resv_a: assert property (CLK_EN && CMD.cmd == 8'h0A |=> RDATA[7:5] == 3'h0)
    else $error("status top bits");
  hyst_resv_a: assert property (CLK_EN && CMD.cmd == 8'h5A |=> RDATA[7:5] == 3'h0)
    else $error("hysteresis top bits");
  status_ro_a: assert property (CMD.wr && CMD.cmd == 8'h0A && !UPDATE |=>
    $stable({ALARM_OUT_FIRST_N, ALARM_OUT_SECOND_N})) else $error("status write moved pins");
  pin_hold_a: assert property (!CMD.wr && !UPDATE |=> $stable(ALARM_OUT_FIRST_N))
    else $error("pin moved without cause");
  first_rb_a: assert property (CLK_EN && CMD.wr && CMD.cmd == 8'h0C ##1 CLK_EN &&
    !CMD.wr && CMD.cmd == 8'h0C |=> RDATA == {3'h0, $past(CMD.wdata[4:0], 2)})
    else $error("first mask readback");
  second_rb_a: assert property (CLK_EN && CMD.wr && CMD.cmd == 8'h0D ##1 CLK_EN &&
    !CMD.wr && CMD.cmd == 8'h0D |=> RDATA == {3'h0, $past(CMD.wdata[4:0], 2)})
    else $error("second mask readback");
  first_block_a: assert property (CLK_EN && CMD.wr && CMD.cmd == 8'h0C &&
    CMD.wdata[4:0] == 5'h1F |=> ALARM_OUT_FIRST_N) else $error("first pin not blocked");
  second_block_a: assert property (CLK_EN && CMD.wr && CMD.cmd == 8'h0D &&
    CMD.wdata[4:0] == 5'h1F |=> ALARM_OUT_SECOND_N) else $error("second pin not blocked");
endmodule
`default_nettype wire

// file: verif/casm_host.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Host side: one command byte per cycle
module casm_host (
  output var casm_pkg::casm_cmd_t cmd
);
  import casm_pkg::*;
  initial cmd = '0;
  // Called on a rising edge; cmd, wr included, holds until the next call
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
    cmd <= '{wr: w, cmd: c, wdata: d};
  endtask
endmodule
`default_nettype wire

// file: verif/casm_alarm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ======================================
// Bench: model compared at every cycle
module casm_alarm_tb_top;
  import casm_pkg::*;
  logic        clk, rst_b = 0, clk_en = 0, upd = 0, en = 1, u, w;
  casm_temps_t rd = '0, lim1 = {5{8'h50}}, lim2 = 40'h5050404050;
  casm_chan_t  m3_in = '0, s1 = '0, s2 = '0, s3 = '0, m1 = 5'h19, m2 = '0, m3 = '0;
  casm_cmd_t   cmd;
  wire [7:0]   rdata;
  wire [2:0]   pin;
  logic [7:0]  erd = '0, c, cmds [5] = '{8'h0A, 8'h0C, 8'h0D, 8'h5A, 8'h33};
  logic [2:0]  epin = 3'h7;
  int          seed = 32'h6758, fail_count = 0, tests_run = 0, hy = 10;
  casm_host host (.cmd(cmd));
  casm_alarm dut (.CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .UPDATE(upd),
    .READING(rd), .FIRST_LIMIT(lim1), .SECOND_LIMIT(lim2), .THIRD_MASK(m3_in), .CMD(cmd),
    .RDATA(rdata), .ALARM_OUT_FIRST_N(pin[2]), .ALARM_OUT_SECOND_N(pin[1]),
    .ALARM_OUT_THIRD_N(pin[0]));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Hysteretic compare; a negative clear point never clears
  function automatic casm_chan_t nx(casm_chan_t p, casm_temps_t l);
    for (int i = 0; i < 5; i++) begin
      if (rd[8*i+:8] >= l[8*i+:8]) p[i] = 1'b1;
      else if (int'(rd[8*i+:8]) < int'(l[8*i+:8]) - hy) p[i] = 1'b0;
    end
    return p;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One cycle: drive, check last result at negedge, then advance the model
  task automatic cyc(input logic uu, input logic ww, input logic [7:0] cc, input logic [7:0] d);
    upd <= uu;
    clk_en <= en;
    host.xfer(ww, cc, d);
    if (uu && en) begin
      m3_in <= 5'($random(seed));
      for (int i = 0; i < 5; i++) rd[8*i+:8] <= 8'h20 + 8'($random(seed) & 8'h3F);
    end
    @(negedge clk);
    chk(rdata, erd);
    chk({5'h00, pin}, {5'h00, epin});
    @(posedge clk);
    if (en) begin
      erd = cc == 8'h0A ? {3'h0, s3} : cc == 8'h0C ? {3'h0, m1} : cc == 8'h0D ? {3'h0, m2} :
            cc == 8'h5A ? {3'h0, 5'(hy)} : 8'h00;
      if (ww && cc == 8'h0C) m1 = d[4:0];
      if (ww && cc == 8'h0D) m2 = d[4:0];
      if (ww && cc == 8'h5A) hy = int'(d[4:0]);
      if (uu) begin
        s1 = nx(s1, lim1);
        s2 = nx(s2, lim2);
        s3 = nx(s3, lim2);
        m3 = m3_in;
      end
      epin = {~|(s1 & ~m1), ~|(s2 & ~m2), ~|(s3 & ~m3)};
    end
  endtask
  task automatic results;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (cmds[i]) cyc(1'b0, 1'b0, cmds[i], 8'h00);
    cyc(1'b0, 1'b1, 8'h0A, 8'hFF);
    cyc(1'b0, 1'b1, 8'h0C, 8'hFF);
    cyc(1'b0, 1'b0, 8'h0C, 8'h00);
    cyc(1'b0, 1'b1, 8'h0D, 8'h1F);
    cyc(1'b0, 1'b0, 8'h0D, 8'h00);
    repeat (600) begin
      en = ($random(seed) & 7) != 0;
      c = cmds[$unsigned($random(seed)) % 5];
      w = 1'($random(seed));
      u = 1'($random(seed)) & ~(w && c == 8'h5A);
      cyc(u, w, c, 8'($random(seed)));
    end
    en = 1'b1;
    cyc(1'b0, 1'b0, 8'h0A, 8'h00);
    results;
  end
endmodule
bind casm_alarm casm_props chk (.CORE_CLK, .RST_B, .CLK_EN, .UPDATE, .CMD, .RDATA,
  .ALARM_OUT_FIRST_N, .ALARM_OUT_SECOND_N, .ALARM_OUT_THIRD_N);
`default_nettype wire
